// [core/glsr_regs.vh]
// Purpose: Register map and field layout of the listener/SRQ/remote block
// Assumes: Avalon-MM word addressing by byte offset, 32-bit data
// Notes:   Offsets are byte addresses of aligned words
`ifndef GLSR_REGS_VH
`define GLSR_REGS_VH

`define GLSR_ADDR_W        4
`define GLSR_OFF_BUSCTL    4'h0
`define GLSR_OFF_INTCTL    4'h4
`define GLSR_OFF_LISTDATA  4'h8
`define GLSR_OFF_XFER      4'hc

// Bus control register fields
`define GLSR_BC_LCMD       0
`define GLSR_BC_LDATA      1
`define GLSR_BC_SRQ        2
`define GLSR_BC_REN        3

// Interrupt control register: enables [7:0], sticky status [15:8]
`define GLSR_IRQ_REN       1
`define GLSR_IRQ_RDY       2
`define GLSR_IRQ_SRQ       4
`define GLSR_IRQ_W         8
`define GLSR_STAT_LSB      8
`define GLSR_IRQ_HI        3'h1

// Listener data register fields
`define GLSR_LD_REN        8
`define GLSR_LD_ATN        9
`define GLSR_LD_EOI        10
`define GLSR_LD_RELEASED   11

// Transfer register fields
`define GLSR_XF_GO         0
`define GLSR_XF_IN         1
`define GLSR_XF_ABORT      2
`define GLSR_XF_INIT       3

`endif

// [core/glsr_edge.v]
// Purpose: Rising- and falling-edge detector for a synchronous bus line level
// Assumes: Input already synchronous to sys_clk
// Notes:   Pulse lasts one cycle
module glsr_edge
(
  // Clock and reset
  input  wire sys_clk,
  input  wire rst,
  // Level in, edges out
  input  wire level_in,
  output wire rise_out,
  output wire fall_out
);
  reg level_q;

  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      level_q <= 1'b0;
    else
      level_q <= level_in;
  end

  assign rise_out = level_in & ~level_q;
  assign fall_out = ~level_in & level_q;
endmodule // glsr_edge

// [core/glsr_core.v]
// Purpose: Listener enable, service request and remote/local logic
// Assumes: Bus lines true-high and synchronous to sys_clk
// Notes:   Avalon-MM slave with one wait state on reads
//          Read answer comes from a flop loaded on the first read cycle
//          Map: 0 bus control, 4 interrupt control,
//          8 listener data (read only), c transfer control
// Behaviour
// - ATN with command listen sets data listen
// - Either listen enable runs acceptor handshake
// - Drive SRQ while service request bit set
// - Foreign SRQ raises interrupt when enabled
// - Drive REN while remote drive bit set
// - Listener data read returns REN with byte
// - REN fall sets sticky flag, interrupts
// - Remote release outranks data ready
// - REN release aborts DMA receive, clears go, when release interrupt enabled
// - Data ready set on byte, cleared on read
`include "glsr_regs.vh"
module glsr_core
(
  // Clock and reset
  input  wire        sys_clk,
  input  wire        rst,
  // Avalon-MM slave
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  // Bus lines in
  input  wire        bus_atn,
  input  wire        bus_eoi,
  input  wire        bus_ren,
  input  wire        bus_srq,
  input  wire [7:0]  bus_dio,
  // Acceptor handshake engine
  input  wire        byte_accepted,
  output wire        acceptor_enable,
  output wire        listen_data_enable,
  output wire        transfer_go,
  output wire        transfer_in,
  // Bus line drives
  output wire        service_request_drive,
  output wire        srq_oe,
  output wire        ren_out,
  output wire        ren_oe,
  // Interrupt
  output wire        irq,
  output wire [1:0]  irq_source
);
  reg        lcmd_q;
  reg        ldata_q;
  reg        srq_q;
  reg        ren_drv_q;
  reg  [7:0] irq_en_q;
  reg        rdy_q;
  reg        released_q;
  reg        srq_seen_q;
  reg  [7:0] data_q;
  reg        go_q;
  reg        in_q;
  reg        abort_q;
  reg        rd_pend_q;
  reg        lcmd_d;
  reg        ldata_d;
  reg        srq_d;
  reg        ren_drv_d;
  reg [31:0] readdata_d;

  wire       atn_rise;
  wire       ren_fall;
  wire       srq_rise;
  wire       wr;
  wire       sel_bc;
  wire       sel_ic;
  wire       sel_ld;
  wire       sel_xf;
  wire       rd_ld;
  wire       ren_abort;
  wire       bc_wr;
  wire       ic_wr;
  wire       rd_take;
  wire       clr_released;
  wire       clr_srq_seen;

  glsr_edge u_atn
  (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .level_in (bus_atn),
    .rise_out (atn_rise),
    .fall_out ()
  );

  glsr_edge u_ren
  (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .level_in (bus_ren),
    .rise_out (),
    .fall_out (ren_fall)
  );

  glsr_edge u_srq
  (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .level_in (bus_srq),
    .rise_out (srq_rise),
    .fall_out ()
  );

  function sel;
    input [3:0] addr;
    input [3:0] off;
    begin
      sel = (addr == off);
    end
  endfunction

  // Writes complete with no wait; reads wait one cycle
  assign avs_waitrequest = avs_read & ~rd_pend_q;
  assign wr     = avs_write & avs_byteenable[0];
  assign sel_bc = sel(avs_address, `GLSR_OFF_BUSCTL);
  assign sel_ic = sel(avs_address, `GLSR_OFF_INTCTL);
  assign sel_ld = sel(avs_address, `GLSR_OFF_LISTDATA);
  assign sel_xf = sel(avs_address, `GLSR_OFF_XFER);
  assign bc_wr  = wr & sel_bc;
  assign ic_wr  = wr & sel_ic;
  // Read state is sampled on the first read cycle, so ready clears there
  assign rd_take = avs_read & ~rd_pend_q;
  assign rd_ld  = rd_take & sel_ld;
  assign clr_released = ic_wr & avs_writedata[`GLSR_STAT_LSB+`GLSR_IRQ_REN];
  assign clr_srq_seen = ic_wr & avs_writedata[`GLSR_STAT_LSB+`GLSR_IRQ_SRQ];

  // Abort only during a receive with the release interrupt enabled
  assign ren_abort = ren_fall & go_q & in_q
                   & irq_en_q[`GLSR_IRQ_REN];

  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      rd_pend_q <= 1'b0;
    else
      rd_pend_q <= avs_read & ~rd_pend_q;
  end

  // Bus control next state
  always @*
  begin
    lcmd_d    = lcmd_q;
    ldata_d   = ldata_q;
    srq_d     = srq_q;
    ren_drv_d = ren_drv_q;
    if (bc_wr)
    begin
      lcmd_d    = avs_writedata[`GLSR_BC_LCMD];
      ldata_d   = avs_writedata[`GLSR_BC_LDATA];
      srq_d     = avs_writedata[`GLSR_BC_SRQ];
      ren_drv_d = avs_writedata[`GLSR_BC_REN];
    end
    // ATN edge beats a clear; held ATN re-sets after it
    if (lcmd_q && atn_rise)
      ldata_d = 1'b1;
    else if (lcmd_q && bus_atn && !bc_wr)
      ldata_d = 1'b1;
  end

  // Bus control register
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      lcmd_q    <= 1'b0;
      ldata_q   <= 1'b0;
      srq_q     <= 1'b0;
      ren_drv_q <= 1'b0;
    end
    else
    begin
      lcmd_q    <= lcmd_d;
      ldata_q   <= ldata_d;
      srq_q     <= srq_d;
      ren_drv_q <= ren_drv_d;
    end
  end

  // Interrupt enables
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      irq_en_q <= 8'h00;
    else if (ic_wr)
      irq_en_q <= avs_writedata[`GLSR_IRQ_W-1:0];
  end

  // Sticky flags, write one to clear, set wins
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      released_q <= 1'b0;
      srq_seen_q <= 1'b0;
    end
    else
    begin
      if (ren_fall)
        released_q <= 1'b1;
      else if (clr_released)
        released_q <= 1'b0;
      if (srq_rise)
        srq_seen_q <= 1'b1;
      else if (clr_srq_seen)
        srq_seen_q <= 1'b0;
    end
  end

  // Received byte and data ready
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rdy_q  <= 1'b0;
      data_q <= 8'h00;
    end
    else if (byte_accepted)
    begin
      rdy_q  <= 1'b1;
      data_q <= bus_dio;
    end
    else if (rd_ld)
      rdy_q  <= 1'b0;
  end

  // Transfer control
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      go_q    <= 1'b0;
      in_q    <= 1'b0;
      abort_q <= 1'b0;
    end
    else
    begin
      if (wr && sel_xf)
      begin
        go_q <= avs_writedata[`GLSR_XF_GO];
        in_q <= avs_writedata[`GLSR_XF_IN];
        if (avs_writedata[`GLSR_XF_INIT])
          abort_q <= 1'b0;
      end
      if (ren_abort)
      begin
        go_q    <= 1'b0;
        abort_q <= 1'b1;
      end
    end
  end

  // Read mux, sampled into the answer flop
  always @*
  begin
    readdata_d = 32'h0000_0000;
    if (sel_bc)
    begin
      readdata_d[`GLSR_BC_LCMD]  = lcmd_q;
      readdata_d[`GLSR_BC_LDATA] = ldata_q;
      readdata_d[`GLSR_BC_SRQ]   = srq_q;
      readdata_d[`GLSR_BC_REN]   = ren_drv_q;
    end
    else if (sel_ic)
    begin
      readdata_d[`GLSR_IRQ_W-1:0] = irq_en_q;
      readdata_d[`GLSR_STAT_LSB+`GLSR_IRQ_REN] = released_q;
      readdata_d[`GLSR_STAT_LSB+`GLSR_IRQ_RDY] = rdy_q;
      readdata_d[`GLSR_STAT_LSB+`GLSR_IRQ_SRQ] = srq_seen_q;
    end
    else if (sel_ld)
    begin
      readdata_d[7:0]               = data_q;
      readdata_d[`GLSR_LD_REN]      = bus_ren;
      readdata_d[`GLSR_LD_ATN]      = bus_atn;
      readdata_d[`GLSR_LD_EOI]      = bus_eoi;
      readdata_d[`GLSR_LD_RELEASED] = released_q;
    end
    else if (sel_xf)
    begin
      readdata_d[`GLSR_XF_GO]    = go_q;
      readdata_d[`GLSR_XF_IN]    = in_q;
      readdata_d[`GLSR_XF_ABORT] = abort_q;
    end
  end

  // One-cycle answer; zero outside it so stale data never shows
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      avs_readdata <= 32'h0000_0000;
    else if (rd_take)
      avs_readdata <= readdata_d;
    else
      avs_readdata <= 32'h0000_0000;
  end

  assign acceptor_enable    = lcmd_q | ldata_q | (go_q & in_q);
  assign listen_data_enable = ldata_q;
  assign transfer_go        = go_q;
  assign transfer_in        = in_q;
  // Lines are true-high: drive a one while enabled
  assign service_request_drive            = 1'b1;
  assign srq_oe             = srq_q;
  assign ren_out            = 1'b1;
  assign ren_oe             = ren_drv_q;

  wire irq_ren = released_q & irq_en_q[`GLSR_IRQ_REN];
  wire irq_rdy = rdy_q      & irq_en_q[`GLSR_IRQ_RDY];
  wire irq_srq = srq_seen_q & irq_en_q[`GLSR_IRQ_SRQ];

  assign irq = irq_ren | irq_rdy | irq_srq;
  // Highest pending source: 1 release, 2 ready, 3 service request
  assign irq_source = irq_ren ? 2'd1 :
                      irq_rdy ? 2'd2 :
                      irq_srq ? 2'd3 : 2'd0;
endmodule // glsr_core

// [dv/glsr_props.sv]
// Purpose: Port checks of glsr_core
// Assumes: One clock, rst async high
// Notes:   Bound from the bench top
module glsr_props
(
  input wire        sys_clk, rst, avs_read, avs_write, avs_waitrequest,
  input wire [3:0]  avs_address, avs_byteenable,
  input wire [31:0] avs_writedata, avs_readdata,
  input wire        bus_atn, bus_ren, acceptor_enable, listen_data_enable,
  input wire        transfer_go, srq_oe, ren_oe, irq,
  input wire [1:0]  irq_source
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire bc_wr = avs_write && avs_byteenable[0] && avs_address == 4'h0;
  property p_srq; bc_wr |=> srq_oe == $past(avs_writedata[2]); endproperty
  a_srq: assert property (p_srq) else $error("srq drive wrong");
  property p_ren; bc_wr |=> ren_oe == $past(avs_writedata[3]); endproperty
  a_ren: assert property (p_ren) else $error("ren drive wrong");
  property p_atn; bus_atn && acceptor_enable && !listen_data_enable &&
    !transfer_go && !avs_write |=> listen_data_enable; endproperty
  a_atn: assert property (p_atn) else $error("listen not set");
  property p_lsn; listen_data_enable |-> acceptor_enable; endproperty
  a_lsn: assert property (p_lsn) else $error("acceptor off");
  property p_rdren; avs_read && !avs_waitrequest && avs_address == 4'h8
    |-> avs_readdata[8] == $past(bus_ren); endproperty
  a_rdren: assert property (p_rdren) else $error("ren bit wrong");
  property p_wait;
    $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("read wait wrong");
  property p_wnw; avs_write |-> !avs_waitrequest; endproperty
  a_wnw: assert property (p_wnw) else $error("write waited");
  property p_irq; irq == (irq_source != 2'h0); endproperty
  a_irq: assert property (p_irq) else $error("irq source wrong");
  c_srq: cover property ($rose(srq_oe));
  c_lsn: cover property ($rose(listen_data_enable));
  c_abt: cover property ($fell(transfer_go));
endmodule // glsr_props

// [dv/glsr_bus_model.sv]
// Purpose: Far-side bus lines seen by glsr_core
// Assumes: True-high wired-OR lines, others set by the bench
// Notes:   EOI left released
module glsr_bus_model
(
  input  wire       srq_oe, ren_oe, atn_req, ren_req, srq_req,
  input  wire [7:0] dio_req,
  output wire       bus_atn, bus_eoi, bus_ren, bus_srq,
  output wire [7:0] bus_dio
);
  timeunit 1ns;
  timeprecision 100ps;
  assign bus_srq = srq_oe | srq_req;
  assign bus_ren = ren_oe | ren_req;
  assign bus_atn = atn_req;
  assign bus_eoi = 1'b0;
  assign bus_dio = dio_req;
endmodule // glsr_bus_model

// [dv/glsr_core_tb.sv]
// Purpose: Self-checking bench of glsr_core
// Assumes: Avalon-MM master tasks, bus model on far side
// Notes:   Table of bus control values, then hand tests
`include "glsr_regs.vh"
module glsr_core_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 0, rst = 1, avs_read = 0, avs_write = 0, byte_accepted = 0;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd_q;
  logic avs_waitrequest, bus_atn, bus_eoi, bus_ren, bus_srq, acceptor_enable,
    listen_data_enable, transfer_go, transfer_in, service_request_drive, srq_oe, ren_out,
    ren_oe, irq, atn_v = 0, ren_v = 1, srq_v = 0;
  logic [7:0] bus_dio;
  logic [1:0] irq_source;
  int fails = 0, total_checks = 0, cyc = 0;
  logic [5:0] rows [4] = '{6'h14, 6'h28, 6'h3c, 6'h03};
  always #2.5 sys_clk = ~sys_clk;
  glsr_core glsr_core_i (.sys_clk(sys_clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .bus_atn(bus_atn), .bus_eoi(bus_eoi), .bus_ren(bus_ren),
    .bus_srq(bus_srq), .bus_dio(bus_dio), .byte_accepted(byte_accepted),
    .acceptor_enable(acceptor_enable), .transfer_in(transfer_in),
    .listen_data_enable(listen_data_enable), .transfer_go(transfer_go),
    .service_request_drive(service_request_drive), .srq_oe(srq_oe), .ren_out(ren_out), .ren_oe(ren_oe),
    .irq(irq), .irq_source(irq_source));
  glsr_bus_model glsr_bus_model_i (.srq_oe(srq_oe), .ren_oe(ren_oe),
    .atn_req(atn_v), .ren_req(ren_v), .srq_req(srq_v), .dio_req(8'ha5),
    .bus_atn(bus_atn), .bus_eoi(bus_eoi), .bus_ren(bus_ren),
    .bus_srq(bus_srq), .bus_dio(bus_dio));
  task chk(input logic [31:0] g, e);
    total_checks++;
    if (g !== e)
    begin
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      fails++;
    end
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
    rd_q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task wait_n(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  task end_sim;
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fails++;
      end_sim;
    end
  end
  initial
  begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    wait_n(0);
    chk({irq, srq_oe, ren_oe, listen_data_enable}, 0);
    chk({service_request_drive, ren_out, transfer_in}, 3'h6);
    bus(0, `GLSR_OFF_LISTDATA, 0);
    chk(rd_q[11:8], 4'h1);
    foreach (rows[i])
    begin
      bus(1, `GLSR_OFF_BUSCTL, rows[i][3:0]);
      wait_n(0);
      chk({ren_oe, srq_oe}, rows[i][5:4]);
      chk(acceptor_enable, |rows[i][1:0]);
      bus(0, `GLSR_OFF_BUSCTL, 0);
      chk(rd_q[3:0], rows[i][3:0]);
    end
    bus(0, 4'h2, 0);
    chk(rd_q, 0);
    bus(1, `GLSR_OFF_BUSCTL, 32'h1);
    @(posedge sys_clk);
    atn_v <= 1'b1;
    wait_n(3);
    chk(listen_data_enable, 1);
    chk(acceptor_enable, 1);
    @(posedge sys_clk);
    atn_v <= 1'b0;
    bus(1, `GLSR_OFF_BUSCTL, 32'h0);
    wait_n(0);
    chk(listen_data_enable, 0);
    bus(1, `GLSR_OFF_INTCTL, 32'h6);
    bus(1, `GLSR_OFF_XFER, 32'h3);
    wait_n(0);
    chk({acceptor_enable, transfer_go, transfer_in}, 3'h7);
    @(posedge sys_clk);
    byte_accepted <= 1'b1;
    @(posedge sys_clk);
    byte_accepted <= 1'b0;
    ren_v <= 1'b0;
    wait_n(3);
    chk({irq, transfer_go, irq_source}, 4'h9);
    bus(0, `GLSR_OFF_XFER, 0);
    chk(rd_q[2:0], 3'h6);
    bus(0, `GLSR_OFF_LISTDATA, 0);
    chk(rd_q[11:0], 12'h8a5);
    bus(1, `GLSR_OFF_INTCTL, 32'h206);
    wait_n(0);
    chk(irq, 0);
    @(posedge sys_clk);
    byte_accepted <= 1'b1;
    @(posedge sys_clk);
    byte_accepted <= 1'b0;
    wait_n(0);
    chk({irq, irq_source}, 3'h6);
    bus(0, `GLSR_OFF_LISTDATA, 0);
    wait_n(0);
    chk(irq, 0);
    bus(1, `GLSR_OFF_XFER, 32'h8);
    bus(1, `GLSR_OFF_XFER, 32'h3);
    bus(0, `GLSR_OFF_XFER, 0);
    chk(rd_q[2:0], 3'h3);
    bus(1, `GLSR_OFF_XFER, 32'h0);
    bus(1, `GLSR_OFF_BUSCTL, 32'h5);
    @(posedge sys_clk);
    atn_v <= 1'b1;
    wait_n(2);
    chk({srq_oe, listen_data_enable}, 2'h3);
    @(posedge sys_clk);
    atn_v <= 1'b0;
    bus(1, `GLSR_OFF_BUSCTL, 32'h3);
    wait_n(2);
    chk({srq_oe, acceptor_enable, listen_data_enable}, 3'h3);
    bus(1, `GLSR_OFF_INTCTL, 32'h1010);
    wait_n(0);
    chk(irq, 0);
    @(posedge sys_clk);
    srq_v <= 1'b1;
    wait_n(2);
    chk({irq, irq_source}, 3'h7);
    bus(1, `GLSR_OFF_INTCTL, 32'h0);
    wait_n(0);
    chk(irq, 0);
    @(posedge sys_clk);
    srq_v <= 1'b0;
    bus(1, `GLSR_OFF_INTCTL, 32'h1000);
    bus(0, `GLSR_OFF_INTCTL, 0);
    chk(rd_q[15:8], 0);
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    wait_n(0);
    chk({acceptor_enable, listen_data_enable, irq, srq_oe}, 0);
    bus(0, `GLSR_OFF_BUSCTL, 0);
    chk(rd_q, 0);
    end_sim;
  end
endmodule // glsr_core_tb
bind glsr_core glsr_props glsr_props_i (.sys_clk(sys_clk), .rst(rst),
  .avs_read(avs_read), .avs_write(avs_write), .bus_ren(bus_ren),
  .avs_waitrequest(avs_waitrequest), .avs_address(avs_address),
  .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .bus_atn(bus_atn), .irq(irq),
  .acceptor_enable(acceptor_enable), .transfer_go(transfer_go),
  .listen_data_enable(listen_data_enable), .srq_oe(srq_oe),
  .ren_oe(ren_oe), .irq_source(irq_source));
